// >>> core/isp_regs.svh
// Constants of the image stream packetizer: limits, reset values, timing counts.
// Assumes a 50 MHz system clock.
`ifndef ISP_REGS_SVH
`define ISP_REGS_SVH

// Clock rate in Hz, also one second of cycles
`define ISP_CLK_HZ       32'h02FA_F080
// Combined IP, UDP and stream header length in bytes
`define ISP_HDR_BYTES    16'h0024
// Default packet length in bytes (payload 1464)
`define ISP_PKT_LEN_RST  16'h05DC
// Largest standard packet, above it jumbo frames are needed
`define ISP_JUMBO_LIMIT  16'h05DC
// Default inter-packet gap in idle clocks
`define ISP_GAP_RST      16'h0032
// Full sensor resolution
`define ISP_MAX_W        13'h1400
`define ISP_MAX_H        13'h1400
// Frame rate limit after reset, in frames per second
`define ISP_RATE_RST     16'h0000
// Header byte positions
`define ISP_HDR_VER_POS  6'h00
`define ISP_HDR_LENH_POS 6'h02
`define ISP_HDR_LENL_POS 6'h03
`define ISP_HDR_BLKH_POS 6'h20
`define ISP_HDR_BLKL_POS 6'h21
`define ISP_HDR_PIDH_POS 6'h22
`define ISP_HDR_PIDL_POS 6'h23
// IPv4 version and header length byte
`define ISP_HDR_VER_VAL  8'h45

`endif

// >>> core/isp_pkg.sv
// Types of the image stream packetizer.
// Assumes isp_regs.svh holds the numeric constants.
package isp_pkg;

   typedef enum logic [3:0] {
      FMT_MONO8    = 4'b0000,
      FMT_BAYER8   = 4'b0001,
      FMT_MONO10P  = 4'b0010,
      FMT_MONO12P  = 4'b0011,
      FMT_BAYER10P = 4'b0100,
      FMT_BAYER12P = 4'b0101,
      FMT_MONO10   = 4'b0110,
      FMT_MONO12   = 4'b0111,
      FMT_BAYER10  = 4'b1000,
      FMT_BAYER12  = 4'b1001,
      FMT_YUV422   = 4'b1010,
      FMT_RGB8     = 4'b1011,
      FMT_BGR8     = 4'b1100,
      FMT_MONO16   = 4'b1101,
      FMT_BAYER16  = 4'b1110
   } isp_fmt_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_HDR  = 3'b001,
      ST_PAY  = 3'b010,
      ST_GAP  = 3'b011,
      ST_DROP = 3'b100
   } isp_state_t;

endpackage : isp_pkg

// >>> core/isp_pair_buffer.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module isp_pair_buffer
   #(parameter int WIDTH = 11)
   (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_b,
   // Filling side
   input  wire logic             inValid,
   input  wire logic [WIDTH-1:0] inData,
   output wire logic             inReady,
   // Draining side
   output wire logic             outValid,
   output wire logic [WIDTH-1:0] outData,
   input  wire logic             outReady
   );

   logic [WIDTH-1:0] mem_reg [0:1];
   logic             wrPtr_reg;
   logic             rdPtr_reg;
   logic [1:0]       count_reg;
   wire              push;
   wire              pop;

   assign inReady  = (count_reg != 2'h2);
   assign outValid = (count_reg != 2'h0);
   assign outData  = mem_reg[rdPtr_reg];
   assign push     = inValid & inReady;
   assign pop      = outValid & outReady;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         mem_reg[0] <= '0;
         mem_reg[1] <= '0;
         wrPtr_reg  <= 1'b0;
         rdPtr_reg  <= 1'b0;
         count_reg  <= 2'h0;
      end
      else
      begin
         if (push)
            mem_reg[wrPtr_reg] <= inData;
         wrPtr_reg <= wrPtr_reg ^ push;
         rdPtr_reg <= rdPtr_reg ^ pop;
         count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
      end
   end

endmodule : isp_pair_buffer

// >>> core/isp_packetizer.sv
// Image stream packetizer: crops, mirrors, formats and packs frames into packets.
// Assumes a frame store that returns the aligned 2x2 cell at srcX/srcY in the same cycle.
`timescale 1ns/1ps
`include "isp_regs.svh"
module isp_packetizer
   import isp_pkg::*;
   #(parameter int unsigned ONE_SECOND_CYCLES = `ISP_CLK_HZ,
     parameter bit          COLOUR_DEVICE     = 1'b0,
     parameter bit          ADC_16BIT         = 1'b0)
   (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // Acquisition commands
   input  wire logic        acqStart,
   input  wire logic        acqStop,
   // Locked configuration, taken on cfgLoad while stopped
   input  wire logic        cfgLoad,
   input  wire logic [12:0] cfgRoiWidth,
   input  wire logic [12:0] cfgRoiHeight,
   input  wire logic [12:0] cfgOffsetX,
   input  wire logic [12:0] cfgOffsetY,
   input  wire logic        cfgReverseX,
   input  wire logic        cfgReverseY,
   input  isp_fmt_t         cfgPixelFormat,
   input  wire logic        cfgRateLimitEn,
   input  wire logic [15:0] cfgRateLimit,
   input  wire logic        cfgCompleteFrameOnStop,
   input  wire logic [15:0] cfgStreamPacketLength,
   // Live gap control
   input  wire logic [15:0] interPacketGap,
   input  wire logic        automaticGapAdjust,
   input  wire logic [15:0] clientGapValue,
   // Status
   output wire logic        acqRunning,
   output wire logic        cfgRejected,
   output wire logic        frameDiscarded,
   output wire logic        jumboRequired,
   output wire logic [15:0] resultingFrameRate,
   output wire logic [15:0] appliedPacketGap,
   output wire logic [12:0] maxWidth,
   output wire logic [12:0] maxHeight,
   // Frame store read
   output wire logic [12:0] srcX,
   output wire logic [12:0] srcY,
   input  wire logic [63:0] srcQuad,
   // Packet byte stream
   output wire logic [7:0]  pktData,
   output wire logic        pktValid,
   input  wire logic        pktReady,
   output wire logic        pktFirst,
   output wire logic        pktLast,
   output wire logic        pktDrop
   );

   function automatic logic fmtOk(isp_fmt_t f);
      logic bayer;
      logic mono;
      bayer = (f == FMT_BAYER8) || (f == FMT_BAYER10P) || (f == FMT_BAYER12P) ||
              (f == FMT_BAYER10) || (f == FMT_BAYER12) || (f == FMT_BAYER16);
      mono  = (f == FMT_MONO8) || (f == FMT_MONO10P) || (f == FMT_MONO12P) ||
              (f == FMT_MONO10) || (f == FMT_MONO12) || (f == FMT_MONO16);
      if ((f == FMT_MONO16 || f == FMT_BAYER16) && !ADC_16BIT)
         return 1'b0;
      if (COLOUR_DEVICE)
         return bayer || f == FMT_RGB8 || f == FMT_BGR8 || f == FMT_YUV422 ||
                f == FMT_MONO8;
      return mono;
   endfunction : fmtOk

   function automatic logic [12:0] mirrorAddr(logic [12:0] off, logic [12:0] len,
                                              logic [12:0] idx, logic rev);
      return off + (rev ? (len - 13'h0001 - idx) : idx);
   endfunction : mirrorAddr

   function automatic logic [11:0] pack12(isp_fmt_t f, logic [15:0] raw);
      return (f == FMT_MONO12P || f == FMT_BAYER12P) ? raw[15:4] : {2'h0, raw[15:6]};
   endfunction : pack12

   function automatic logic [7:0] clip8(logic signed [17:0] v);
      return (v < 0) ? 8'h00 : ((v > 18'sh000FF) ? 8'hFF : v[7:0]);
   endfunction : clip8

   // Bytes of one pixel: {count, byte2, byte1, byte0}, byte0 sent first
   function automatic logic [25:0] pixBytes(isp_fmt_t f, logic [15:0] raw,
                                            logic [7:0] r, logic [7:0] g, logic [7:0] b,
                                            logic ph, logic lastPix, logic [3:0] nib);
      logic [11:0]        p;
      logic signed [17:0] y;
      logic signed [17:0] u;
      logic signed [17:0] v;
      p = pack12(f, raw);
      y = (18'sd77 * $signed({10'h0, r}) + 18'sd150 * $signed({10'h0, g}) +
           18'sd29 * $signed({10'h0, b})) >>> 8;
      u = ((18'sd128 * $signed({10'h0, b}) - 18'sd43 * $signed({10'h0, r}) -
            18'sd85 * $signed({10'h0, g})) >>> 8) + 18'sd128;
      v = ((18'sd128 * $signed({10'h0, r}) - 18'sd107 * $signed({10'h0, g}) -
            18'sd21 * $signed({10'h0, b})) >>> 8) + 18'sd128;
      case (f)
         FMT_MONO8:
            return {2'h1, 16'h0000, COLOUR_DEVICE ? clip8(y) : raw[15:8]};
         FMT_BAYER8:
            return {2'h1, 16'h0000, raw[15:8]};
         FMT_MONO10P, FMT_MONO12P, FMT_BAYER10P, FMT_BAYER12P:
            if (ph)
               return {2'h2, 8'h00, p[11:4], p[3:0], nib};
            else if (lastPix)
               return {2'h2, 8'h00, 4'h0, p[3:0], p[11:4]};
            else
               return {2'h1, 16'h0000, p[11:4]};
         FMT_MONO10, FMT_BAYER10:
            return {2'h2, 8'h00, 6'h00, raw[15:6]};
         FMT_MONO12, FMT_BAYER12:
            return {2'h2, 8'h00, 4'h0, raw[15:4]};
         FMT_MONO16, FMT_BAYER16:
            return {2'h2, 8'h00, raw};
         FMT_YUV422:
            return {2'h2, 8'h00, ph ? clip8(v) : clip8(u), clip8(y)};
         FMT_RGB8:
            return {2'h3, b, g, r};
         FMT_BGR8:
            return {2'h3, r, g, b};
         default:
            return {2'h1, 16'h0000, raw[15:8]};
      endcase
   endfunction : pixBytes

   function automatic logic [7:0] hdrByte(logic [5:0] idx, logic [15:0] len,
                                          logic [15:0] blk, logic [15:0] pid);
      case (idx)
         `ISP_HDR_VER_POS:  return `ISP_HDR_VER_VAL;
         `ISP_HDR_LENH_POS: return len[15:8];
         `ISP_HDR_LENL_POS: return len[7:0];
         `ISP_HDR_BLKH_POS: return blk[15:8];
         `ISP_HDR_BLKL_POS: return blk[7:0];
         `ISP_HDR_PIDH_POS: return pid[15:8];
         `ISP_HDR_PIDL_POS: return pid[7:0];
         default:           return 8'h00;
      endcase
   endfunction : hdrByte

   isp_state_t  state_reg;
   isp_state_t  state_next;
   logic [12:0] roiW_reg, roiH_reg, offX_reg, offY_reg;
   logic        revX_reg, revY_reg, rateEn_reg, complete_reg;
   isp_fmt_t    fmt_reg;
   logic [15:0] rate_reg, pktLen_reg;
   logic        running_reg, rejected_reg, discard_reg, credit_reg, frameDone_reg;
   logic [25:0] accum_reg;
   logic [31:0] winCnt_reg;
   logic [15:0] frameCnt_reg, result_reg, gap_reg;
   logic [12:0] col_reg, row_reg, srcX_reg, srcY_reg;
   logic [1:0]  byteSel_reg;
   logic        phase_reg;
   logic [3:0]  nib_reg;
   logic [5:0]  hdrIdx_reg;
   logic [15:0] payCnt_reg, gapCnt_reg, pktId_reg, blkId_reg;

   // Command and configuration decode
   wire cfgAccept  = cfgLoad && !running_reg && state_reg == ST_IDLE;
   wire startCmd   = acqStart && !acqStop;
   wire abortNow   = acqStop && !complete_reg;
   wire slotOk     = !rateEn_reg || credit_reg;
   wire frameGo    = state_reg == ST_IDLE && running_reg && !acqStop && slotOk;
   wire winEnd     = winCnt_reg == (ONE_SECOND_CYCLES - 32'h0000_0001);

   // Rate slot accumulator, slots counted against the same window as the report
   wire [31:0] rateSum = {6'h00, accum_reg} + {16'h0000, rate_reg};
   wire        hitSlot = rateSum >= ONE_SECOND_CYCLES;
   wire [31:0] rateRem = rateSum - ONE_SECOND_CYCLES;

   // Pixel selection from the aligned cell
   wire [15:0] rawSample = srcQuad[{srcY_reg[0], srcX_reg[0], 4'h0} +: 16];
   wire [11:0] pixPacked = pack12(fmt_reg, rawSample);
   wire [16:0] gSum      = {1'b0, srcQuad[31:16]} + {1'b0, srcQuad[47:32]};
   wire        lastCol   = col_reg == (roiW_reg - 13'h0001);
   wire        lastRow   = row_reg == (roiH_reg - 13'h0001);
   wire [25:0] pix       = pixBytes(fmt_reg, rawSample, srcQuad[63:56], gSum[16:9],
                                    srcQuad[15:8], phase_reg, lastCol && lastRow,
                                    nib_reg);
   wire [7:0]  pixByte   = pix[{byteSel_reg, 3'h0} +: 8];
   wire        lastByte  = byteSel_reg == (pix[25:24] - 2'h1);
   wire        frameEnd  = lastByte && lastCol && lastRow;

   // Packet sequencing decode
   wire [15:0] payLen    = (pktLen_reg > `ISP_HDR_BYTES) ? (pktLen_reg - `ISP_HDR_BYTES)
                                                          : 16'h0001;
   wire        hdrLast   = {10'h000, hdrIdx_reg} == (`ISP_HDR_BYTES - 16'h0001);
   wire        pktEnd    = (payCnt_reg == (payLen - 16'h0001)) || frameEnd;
   wire        gapDone   = (gapCnt_reg + 16'h0001) >= gap_reg;
   wire        inHdr     = state_reg == ST_HDR;
   wire        inPay     = state_reg == ST_PAY;
   wire        inDrop    = state_reg == ST_DROP;
   wire        bufInReady;
   wire        bufInValid = ((inHdr || inPay) && !abortNow) || inDrop;
   wire        step       = bufInValid && bufInReady;
   wire        pixStep    = inPay && step && lastByte;
   wire [7:0]  hdrData    = hdrByte(hdrIdx_reg, pktLen_reg, blkId_reg, pktId_reg);
   wire [10:0] bufInWord  = inHdr ? {hdrIdx_reg == 6'h00, 2'h0, hdrData} :
                            inPay ? {1'b0, pktEnd, 1'b0, pixByte} :
                                    {3'h3, 8'h00};
   wire [10:0] bufOutWord;

   // Scan position and mirrored address
   wire [12:0] colNext = frameGo ? 13'h0000 :
                         pixStep ? (lastCol ? 13'h0000 : col_reg + 13'h0001) : col_reg;
   wire [12:0] rowNext = frameGo ? 13'h0000 :
                         (pixStep && lastCol) ? row_reg + 13'h0001 : row_reg;

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:
            if (frameGo)
               state_next = ST_HDR;
         ST_HDR:
            if (abortNow)
               state_next = ST_DROP;
            else if (step && hdrLast)
               state_next = ST_PAY;
         ST_PAY:
            if (abortNow)
               state_next = ST_DROP;
            else if (step && pktEnd)
               state_next = ST_GAP;
         ST_GAP:
            if (abortNow && !frameDone_reg)
               state_next = ST_IDLE;
            else if (gapDone)
               state_next = frameDone_reg ? ST_IDLE : ST_HDR;
         ST_DROP:
            if (step)
               state_next = ST_IDLE;
         default:
            state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         roiW_reg     <= `ISP_MAX_W;
         roiH_reg     <= `ISP_MAX_H;
         offX_reg     <= 13'h0000;
         offY_reg     <= 13'h0000;
         revX_reg     <= 1'b0;
         revY_reg     <= 1'b0;
         fmt_reg      <= COLOUR_DEVICE ? FMT_BAYER8 : FMT_MONO8;
         rateEn_reg   <= 1'b0;
         rate_reg     <= `ISP_RATE_RST;
         complete_reg <= 1'b0;
         pktLen_reg   <= `ISP_PKT_LEN_RST;
         rejected_reg <= 1'b0;
      end
      else
      begin
         rejected_reg <= cfgLoad && (!cfgAccept || !fmtOk(cfgPixelFormat));
         if (cfgAccept)
         begin
            roiW_reg     <= cfgRoiWidth;
            roiH_reg     <= cfgRoiHeight;
            offX_reg     <= cfgOffsetX;
            offY_reg     <= cfgOffsetY;
            revX_reg     <= cfgReverseX;
            revY_reg     <= cfgReverseY;
            fmt_reg      <= fmtOk(cfgPixelFormat) ? cfgPixelFormat : fmt_reg;
            rateEn_reg   <= cfgRateLimitEn;
            rate_reg     <= cfgRateLimit;
            complete_reg <= cfgCompleteFrameOnStop;
            pktLen_reg   <= cfgStreamPacketLength;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         running_reg  <= 1'b0;
         credit_reg   <= 1'b0;
         accum_reg    <= 26'h000_0000;
         winCnt_reg   <= 32'h0000_0000;
         frameCnt_reg <= 16'h0000;
         result_reg   <= 16'h0000;
         gap_reg      <= `ISP_GAP_RST;
      end
      else
      begin
         running_reg  <= acqStop ? 1'b0 : (startCmd ? 1'b1 : running_reg);
         accum_reg    <= !rateEn_reg ? 26'h000_0000 :
                         (hitSlot ? rateRem[25:0] : rateSum[25:0]);
         credit_reg   <= rateEn_reg && (hitSlot || (credit_reg && !frameGo));
         winCnt_reg   <= winEnd ? 32'h0000_0000 : winCnt_reg + 32'h0000_0001;
         frameCnt_reg <= (winEnd ? 16'h0000 : frameCnt_reg) + {15'h0000, frameGo};
         if (winEnd)
            result_reg <= frameCnt_reg + {15'h0000, frameGo};
         gap_reg      <= automaticGapAdjust ? clientGapValue : interPacketGap;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_reg     <= ST_IDLE;
         col_reg       <= 13'h0000;
         row_reg       <= 13'h0000;
         srcX_reg      <= 13'h0000;
         srcY_reg      <= 13'h0000;
         byteSel_reg   <= 2'h0;
         phase_reg     <= 1'b0;
         nib_reg       <= 4'h0;
         hdrIdx_reg    <= 6'h00;
         payCnt_reg    <= 16'h0000;
         gapCnt_reg    <= 16'h0000;
         pktId_reg     <= 16'h0000;
         blkId_reg     <= 16'h0000;
         frameDone_reg <= 1'b0;
         discard_reg   <= 1'b0;
      end
      else
      begin
         state_reg   <= state_next;
         col_reg     <= colNext;
         row_reg     <= rowNext;
         srcX_reg    <= mirrorAddr(offX_reg, roiW_reg, colNext, revX_reg);
         srcY_reg    <= mirrorAddr(offY_reg, roiH_reg, rowNext, revY_reg);
         byteSel_reg <= (frameGo || pixStep) ? 2'h0 :
                        ((inPay && step) ? byteSel_reg + 2'h1 : byteSel_reg);
         phase_reg   <= frameGo ? 1'b0 : phase_reg ^ pixStep;
         if (pixStep && !phase_reg)
            nib_reg <= pixPacked[3:0];
         hdrIdx_reg  <= (inHdr && step) ? (hdrLast ? 6'h00 : hdrIdx_reg + 6'h01)
                                        : (inHdr ? hdrIdx_reg : 6'h00);
         payCnt_reg  <= inHdr ? 16'h0000 :
                        ((inPay && step) ? payCnt_reg + 16'h0001 : payCnt_reg);
         gapCnt_reg  <= (state_reg == ST_GAP) ? gapCnt_reg + 16'h0001 : 16'h0000;
         if (inPay && step && pktEnd)
            pktId_reg <= pktId_reg + 16'h0001;
         if (frameGo)
            blkId_reg <= blkId_reg + 16'h0001;
         frameDone_reg <= frameGo ? 1'b0 : (frameDone_reg || (inPay && step && frameEnd));
         discard_reg   <= (state_next == ST_DROP && state_reg != ST_DROP) ||
                          (state_reg == ST_GAP && abortNow && !frameDone_reg);
      end
   end

   isp_pair_buffer #(.WIDTH(11)) u_buf
   (
      .clk      (clk),
      .rst_b    (rst_b),
      .inValid  (bufInValid),
      .inData   (bufInWord),
      .inReady  (bufInReady),
      .outValid (pktValid),
      .outData  (bufOutWord),
      .outReady (pktReady)
   );

   assign pktFirst           = bufOutWord[10];
   assign pktLast            = bufOutWord[9];
   assign pktDrop            = bufOutWord[8];
   assign pktData            = bufOutWord[7:0];
   assign acqRunning         = running_reg;
   assign cfgRejected        = rejected_reg;
   assign frameDiscarded     = discard_reg;
   assign jumboRequired      = pktLen_reg > `ISP_JUMBO_LIMIT;
   assign resultingFrameRate = result_reg;
   assign appliedPacketGap   = gap_reg;
   assign maxWidth           = `ISP_MAX_W;
   assign maxHeight          = `ISP_MAX_H;
   assign srcX               = srcX_reg;
   assign srcY               = srcY_reg;

endmodule : isp_packetizer

// >>> tb/isp_host_model.sv
// Host side: packet sink that can stall, plus the frame store.
// Assumes the bench picks when the host stalls.
`timescale 1ns/1ps
module isp_host_model
   (
   // Control
   input  wire logic        clk,
   input  wire logic        stall,
   // Frame store
   input  wire logic [12:0] srcX,
   input  wire logic [12:0] srcY,
   output logic      [63:0] srcQuad,
   // Packet sink
   output wire logic        pktReady
   );
   logic slow = 1'b0;
   always_ff @(posedge clk)
      slow <= ~slow;
   // Any packet length is accepted
   assign pktReady = !(stall && slow);
   // Sample top byte is {y, x} of the pixel
   always_comb
      for (int i = 0; i < 4; i++)
         srcQuad[i*16 +: 16] = {srcY[3:1], i[1], srcX[3:1], i[0], 8'h00};
endmodule : isp_host_model

// >>> tb/isp_packetizer_chk.sv
// Port assertions of the packetizer.
// Assumes one clock and the active-low reset.
`timescale 1ns/1ps
module isp_packetizer_chk
   (
   input wire logic clk, rst_b, acqStart, acqStop, cfgLoad, acqRunning, cfgRejected,
   input wire logic frameDiscarded, automaticGapAdjust, pktValid, pktReady, pktFirst,
   input wire logic pktLast, pktDrop,
   input wire logic [15:0] clientGapValue, interPacketGap, appliedPacketGap,
   input wire logic [12:0] maxWidth,
   input wire logic [7:0]  pktData
   );
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_max_width:
      assert property (maxWidth == 13'h1400) else $error("max width");
   a_gap_applied:
      assert property ($past(rst_b) |-> appliedPacketGap == ($past(automaticGapAdjust) ?
         $past(clientGapValue) : $past(interPacketGap))) else $error("applied gap");
   a_run_start:
      assert property (acqStart && !acqStop |=> acqRunning) else $error("start");
   a_run_stop:
      assert property (acqStop |=> !acqRunning) else $error("stop");
   a_cfg_refuse:
      assert property (cfgLoad && acqRunning |=> cfgRejected) else $error("refuse");
   a_first_hdr:
      assert property (pktValid && pktFirst |-> pktData == 8'h45) else $error("header");
   a_hold_data:
      assert property (pktValid && !pktReady |=> pktValid && $stable(pktData)) else $error("hold");
   a_drop_word:
      assert property (pktValid && pktDrop |-> pktLast && pktData == 8'h00) else $error("drop");
   c_drop: cover property (frameDiscarded);
   c_last: cover property (pktValid && pktReady && pktLast);
   c_reject: cover property (cfgRejected);
endmodule : isp_packetizer_chk
bind isp_packetizer isp_packetizer_chk i_chk (.*);

// >>> tb/tb_isp_packetizer.sv
// Self-checking bench of the image stream packetizer.
// Assumes the host model serves the frame store and the sink.
`timescale 1ns/1ps
module tb_isp_packetizer import isp_pkg::*;;
   logic        clk = 1'b0, rst_b = 1'b0, acqStart = 1'b0, acqStop = 1'b0, cfgLoad = 1'b0;
   logic        cfgReverseX = 1'b0, cfgReverseY = 1'b0, cfgRateLimitEn = 1'b0, stall = 1'b0;
   logic        cfgCompleteFrameOnStop = 1'b0, automaticGapAdjust = 1'b0;
   logic [12:0] cfgRoiWidth = 13'h0004, cfgRoiHeight = 13'h0002;
   logic [12:0] cfgOffsetX = 13'h0002, cfgOffsetY = 13'h0001;
   logic [15:0] cfgRateLimit = 16'h0000, cfgStreamPacketLength = 16'h0028;
   logic [15:0] interPacketGap = 16'h0006, clientGapValue = 16'h0007;
   isp_fmt_t    cfgPixelFormat = FMT_MONO8;
   logic        acqRunning, cfgRejected, frameDiscarded, jumboRequired, pktValid, pktReady;
   logic        pktFirst, pktLast, pktDrop;
   logic [15:0] resultingFrameRate, appliedPacketGap;
   logic [12:0] maxWidth, maxHeight, srcX, srcY;
   logic [63:0] srcQuad;
   logic [7:0]  pktData;
   int          fail_count = 0, compares = 0;
   isp_packetizer #(.ONE_SECOND_CYCLES(1000)) i_dut (.*);
   isp_host_model i_host (.*);
   always #10 clk = ~clk;
   task automatic check(input logic [15:0] got, exp);
      compares++;
      if (got !== exp)
      begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         fail_count++;
      end
   endtask : check
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask : pulse
   task automatic tally_and_finish;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : tally_and_finish
   // One 4x2 frame in two packets, stopped at payload byte stopAt
   task automatic run_frame(input logic rev, full, input int stopAt);
      int p, k, idle;
      logic disc, done;
      logic [3:0] x;
      p = 0;
      k = 0;
      idle = 99;
      disc = 1'b0;
      done = 1'b0;
      repeat (8) @(negedge clk);
      cfgReverseX = rev;
      cfgReverseY = rev;
      cfgCompleteFrameOnStop = full;
      stall = !full;
      pulse(cfgLoad);
      check(cfgRejected, 1'b0);
      pulse(acqStart);
      pulse(cfgLoad);
      check(cfgRejected, 1'b1);
      for (int t = 0; t < 3000 && !done; t++)
      begin
         acqStop = (p == stopAt);
         disc |= frameDiscarded;
         idle = pktValid ? idle : idle + 1;
         if (pktValid && pktReady)
         begin
            if (pktFirst && full)
               check(idle >= 6, 1'b1);
            if (k == 3)
               check(pktData, 8'h28);
            else if (k >= 36 && !pktDrop)
            begin
               x = rev ? 4'h5 - p[1:0] : 4'h2 + p[1:0];
               check(pktData, {(p[2] ^ rev) ? 4'h2 : 4'h1, x});
               p++;
            end
            done = pktDrop || (pktLast && p == 8);
            idle = 0;
            k = pktLast ? 0 : k + 1;
         end
         @(negedge clk);
      end
      if (!done)
      begin
         fail_count++;
         tally_and_finish();
      end
      check(p == 8, full);
      check(disc, !full);
      check(acqRunning, 1'b0);
      acqStop = 1'b0;
   endtask : run_frame
   // Frame starts counted over one window, limited or free running
   task automatic rate_run(input logic en, input logic [15:0] lim);
      cfgRateLimitEn = en;
      cfgRateLimit = lim;
      stall = 1'b0;
      repeat (10) @(negedge clk);
      pulse(cfgLoad);
      pulse(acqStart);
      repeat (2100) @(negedge clk);
      if (en)
         check(resultingFrameRate, lim);
      else
         check(resultingFrameRate > 16'h0004, 1'b1);
      pulse(acqStop);
   endtask : rate_run
   initial
   begin
      repeat (8) @(negedge clk);
      check(appliedPacketGap, 16'h0032);
      check(jumboRequired, 1'b0);
      check(maxHeight, 13'h1400);
      rst_b = 1'b1;
      @(negedge clk);
      check(maxWidth, 13'h1400);
      check(appliedPacketGap, interPacketGap);
      automaticGapAdjust = 1'b1;
      repeat (2) @(negedge clk);
      check(appliedPacketGap, clientGapValue);
      automaticGapAdjust = 1'b0;
      cfgPixelFormat = FMT_MONO16;
      cfgStreamPacketLength = 16'h05DD;
      pulse(cfgLoad);
      check(cfgRejected, 1'b1);
      check(jumboRequired, 1'b1);
      cfgPixelFormat = FMT_MONO8;
      cfgStreamPacketLength = 16'h0028;
      run_frame(1'b1, 1'b1, 5);
      run_frame(1'b0, 1'b0, 2);
      rate_run(1'b1, 16'h0004);
      rate_run(1'b0, 16'h0004);
      tally_and_finish();
   end
endmodule : tb_isp_packetizer
